// >>> hw/dpp_ctrl.v
/*
  Phase offset and pattern control register bank of a four-channel
  waveform generator, reached over the device's serial port.
  Assumes serial pins are asynchronous to clk and the synthesizer MSBs
  and pattern memory data come from logic on clk.
*/
// Contract
// - Four 16-bit phase words, read/write, reset zero.
// - Phase word scales linearly over one cycle.
// - Trigger delay mode bit one, global, reset zero.
// - Cosine select bits make channel output cosine.
// - Counter clock select: DAC clock or MSB edge.
// - Channel three phase from memory top bits.
// - Memory bit clear uses channel three register.
`timescale 1ns/1ps
`default_nettype none
`include "dpp_ctrl_regs.vh"

module dpp_ctrl (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Serial port pins
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_mosi,
  output reg spi_miso_q,
  output reg spi_miso_oe_n_q,
  // Synthesizer and pattern memory side
  input wire [3:0] synth_msb,
  input wire [11:0] chan3_start_address_data,
  // Channel phase words after source and cosine selection
  output wire [15:0] chan1_phase_word,
  output wire [15:0] chan2_phase_word,
  output wire [15:0] chan3_phase_word,
  output wire [15:0] chan4_phase_word,
  // Address counter step enables per channel
  output wire [3:0] addr_step,
  // Pattern control levels
  output reg first_pattern_only_delay_q,
  output reg chan4_cosine_select_q,
  output reg chan3_cosine_select_q,
  output reg chan4_counter_clock_select_q,
  output reg chan3_counter_clock_select_q,
  output reg chan3_phase_from_memory_q
);

  // -------------------------------------------------------------------
  // Register storage
  // -------------------------------------------------------------------
  reg [15:0] chan4_phase_offset_q;
  reg [15:0] chan3_phase_offset_q;
  reg [15:0] chan2_phase_offset_q;
  reg [15:0] chan1_phase_offset_q;
  reg [15:0] pattern_control_one_q;
  reg [15:0] pattern_control_two_q;

  // -------------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------------
  reg [2:0] sclk_sync_q;
  reg [1:0] cs_sync_q;
  reg [1:0] mosi_sync_q;

  // -------------------------------------------------------------------
  // Serial frame state
  // -------------------------------------------------------------------
  reg [5:0] bit_cnt_q;
  reg [14:0] shift_in_q;
  reg read_phase_q;
  reg [14:0] addr_q;
  reg [15:0] shift_out_q;

  wire sclk_rise;
  wire sclk_fall;
  wire cs_active;
  wire [14:0] header_addr;
  wire [15:0] write_data;

  // Read decode shared by the header capture path.
  function [15:0] dpp_read_reg;
    input [14:0] addr;
    begin
      if (addr == `DPP_ADDR_CHAN4_PHASE)
        dpp_read_reg = chan4_phase_offset_q;
      else if (addr == `DPP_ADDR_CHAN3_PHASE)
        dpp_read_reg = chan3_phase_offset_q;
      else if (addr == `DPP_ADDR_CHAN2_PHASE)
        dpp_read_reg = chan2_phase_offset_q;
      else if (addr == `DPP_ADDR_CHAN1_PHASE)
        dpp_read_reg = chan1_phase_offset_q;
      else if (addr == `DPP_ADDR_PAT_CTRL1)
        dpp_read_reg = pattern_control_one_q;
      else if (addr == `DPP_ADDR_PAT_CTRL2)
        dpp_read_reg = pattern_control_two_q;
      else
        dpp_read_reg = `DPP_UNMAPPED_READ;
    end
  endfunction

  // Two flops per pin; the third sclk stage only feeds edge detection.
  always @(posedge clk)
  begin
    if (srst)
    begin
      sclk_sync_q <= 3'h0;
      cs_sync_q <= 2'h3;
      mosi_sync_q <= 2'h0;
    end
    else
    begin
      sclk_sync_q <= {sclk_sync_q[1:0], spi_sclk};
      cs_sync_q <= {cs_sync_q[0], spi_cs_n};
      mosi_sync_q <= {mosi_sync_q[0], spi_mosi};
    end
  end

  // Edge and frame qualifiers built from settled synchroniser stages.
  assign sclk_rise = sclk_sync_q[1] & ~sclk_sync_q[2];
  assign sclk_fall = ~sclk_sync_q[1] & sclk_sync_q[2];
  assign cs_active = ~cs_sync_q[1];
  assign header_addr = {shift_in_q[13:0], mosi_sync_q[1]};
  assign write_data = {shift_in_q[14:0], mosi_sync_q[1]};

  // -------------------------------------------------------------------
  // Serial frame engine
  // -------------------------------------------------------------------

  // Shift in 32 bits: read flag, 15-bit address, 16-bit data.
  always @(posedge clk)
  begin
    if (srst)
    begin
      bit_cnt_q <= 6'h00;
      shift_in_q <= 15'h0000;
      read_phase_q <= 1'b0;
      addr_q <= 15'h0000;
      shift_out_q <= 16'h0000;
      spi_miso_q <= 1'b0;
      spi_miso_oe_n_q <= 1'b1;
    end
    else if (!cs_active)
    begin
      // Deselect aborts any partial frame.
      bit_cnt_q <= 6'h00;
      read_phase_q <= 1'b0;
      spi_miso_oe_n_q <= 1'b1;
    end
    else
    begin
      if (sclk_rise)
      begin
        // Only the last 15 bits are ever read, so older bits fall off.
        shift_in_q <= {shift_in_q[13:0], mosi_sync_q[1]};
        bit_cnt_q <= bit_cnt_q + 6'h01;
        if (bit_cnt_q == `DPP_HEADER_LAST_BIT)
        begin
          addr_q <= header_addr;
          read_phase_q <= shift_in_q[14];
          shift_out_q <= dpp_read_reg(header_addr);
        end
      end
      else if (sclk_fall && read_phase_q)
      begin
        // Master samples on rising edges, so drive on falling ones.
        spi_miso_q <= shift_out_q[15];
        shift_out_q <= {shift_out_q[14:0], 1'b0};
        spi_miso_oe_n_q <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------
  // Register writes
  // -------------------------------------------------------------------

  // Store the full word at the last data bit of a write frame.
  always @(posedge clk)
  begin
    if (srst)
    begin
      chan4_phase_offset_q <= `DPP_RST_PHASE;
      chan3_phase_offset_q <= `DPP_RST_PHASE;
      chan2_phase_offset_q <= `DPP_RST_PHASE;
      chan1_phase_offset_q <= `DPP_RST_PHASE;
      pattern_control_one_q <= `DPP_RST_PAT_CTRL1;
      pattern_control_two_q <= `DPP_RST_PAT_CTRL2;
    end
    else if (cs_active && sclk_rise && !read_phase_q &&
             bit_cnt_q == `DPP_FRAME_LAST_BIT)
    begin
      // Reserved bits are kept and read back but drive nothing.
      if (addr_q == `DPP_ADDR_CHAN4_PHASE)
        chan4_phase_offset_q <= write_data;
      else if (addr_q == `DPP_ADDR_CHAN3_PHASE)
        chan3_phase_offset_q <= write_data;
      else if (addr_q == `DPP_ADDR_CHAN2_PHASE)
        chan2_phase_offset_q <= write_data;
      else if (addr_q == `DPP_ADDR_CHAN1_PHASE)
        chan1_phase_offset_q <= write_data;
      else if (addr_q == `DPP_ADDR_PAT_CTRL1)
        pattern_control_one_q <= write_data;
      else if (addr_q == `DPP_ADDR_PAT_CTRL2)
        pattern_control_two_q <= write_data;
    end
  end

  // -------------------------------------------------------------------
  // Control bit outputs
  // -------------------------------------------------------------------

  // Mirror control fields to flops that feed the pattern logic.
  always @(posedge clk)
  begin
    if (srst)
    begin
      first_pattern_only_delay_q <= 1'b0;
      chan4_cosine_select_q <= 1'b0;
      chan3_cosine_select_q <= 1'b0;
      chan4_counter_clock_select_q <= 1'b0;
      chan3_counter_clock_select_q <= 1'b0;
      chan3_phase_from_memory_q <= 1'b0;
    end
    else
    begin
      // Set: delay only before the first pattern; clear: every pass.
      first_pattern_only_delay_q <=
        pattern_control_one_q[`DPP_BIT_FIRST_ONLY_DELAY];
      chan4_cosine_select_q <=
        pattern_control_two_q[`DPP_BIT_CHAN4_COSINE];
      chan3_cosine_select_q <=
        pattern_control_two_q[`DPP_BIT_CHAN3_COSINE];
      chan4_counter_clock_select_q <=
        pattern_control_two_q[`DPP_BIT_CHAN4_CNT_CLK];
      chan3_counter_clock_select_q <=
        pattern_control_two_q[`DPP_BIT_CHAN3_CNT_CLK];
      chan3_phase_from_memory_q <=
        pattern_control_two_q[`DPP_BIT_CHAN3_PHASE_MEM];
    end
  end

  // -------------------------------------------------------------------
  // Channel phase paths
  // -------------------------------------------------------------------

  // Channels one and two have no upper-half controls here.
  dpp_phase_path u_chan1 (
    .clk(clk),
    .srst(srst),
    .offset_word(chan1_phase_offset_q),
    .cosine_select(1'b0),
    .from_memory(1'b0),
    .memory_data(12'h000),
    .counter_clock_select(1'b0),
    .synth_msb(synth_msb[0]),
    .phase_q(chan1_phase_word),
    .step_q(addr_step[0])
  );

  dpp_phase_path u_chan2 (
    .clk(clk),
    .srst(srst),
    .offset_word(chan2_phase_offset_q),
    .cosine_select(1'b0),
    .from_memory(1'b0),
    .memory_data(12'h000),
    .counter_clock_select(1'b0),
    .synth_msb(synth_msb[1]),
    .phase_q(chan2_phase_word),
    .step_q(addr_step[1])
  );

  // Channel three may take its phase from pattern memory.
  dpp_phase_path u_chan3 (
    .clk(clk),
    .srst(srst),
    .offset_word(chan3_phase_offset_q),
    .cosine_select(chan3_cosine_select_q),
    .from_memory(chan3_phase_from_memory_q),
    .memory_data(chan3_start_address_data),
    .counter_clock_select(chan3_counter_clock_select_q),
    .synth_msb(synth_msb[2]),
    .phase_q(chan3_phase_word),
    .step_q(addr_step[2])
  );

  dpp_phase_path u_chan4 (
    .clk(clk),
    .srst(srst),
    .offset_word(chan4_phase_offset_q),
    .cosine_select(chan4_cosine_select_q),
    .from_memory(1'b0),
    .memory_data(12'h000),
    .counter_clock_select(chan4_counter_clock_select_q),
    .synth_msb(synth_msb[3]),
    .phase_q(chan4_phase_word),
    .step_q(addr_step[3])
  );

endmodule // dpp_ctrl

`default_nettype wire

// >>> hw/dpp_phase_path.v
/*
  One synthesizer channel's phase path: selects the phase source, adds
  the cosine quarter-cycle shift and makes the address counter step.
  Assumes all inputs come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dpp_ctrl_regs.vh"

module dpp_phase_path (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Configuration
  input wire [15:0] offset_word,
  input wire cosine_select,
  input wire from_memory,
  input wire [11:0] memory_data,
  input wire counter_clock_select,
  // Synthesizer side
  input wire synth_msb,
  output reg [15:0] phase_q,
  output reg step_q
);

  reg msb_prev_q;
  reg [15:0] source_d;
  reg [15:0] phase_d;
  reg step_d;

  // Pick the phase source and add a quarter cycle for cosine output.
  always @*
  begin
    if (from_memory)
      source_d = {memory_data[11:4], 8'h00};
    else
      source_d = offset_word;
    // The word wraps modulo one full cycle, so 0x4000 is 90 degrees.
    if (cosine_select)
      phase_d = source_d + `DPP_QUARTER_CYCLE;
    else
      phase_d = source_d;
    // DAC clock steps every cycle; else step on the MSB rising edge.
    if (counter_clock_select)
      step_d = synth_msb & ~msb_prev_q;
    else
      step_d = 1'b1;
  end

  // Registered outputs.
  always @(posedge clk)
  begin
    if (srst)
    begin
      msb_prev_q <= 1'b0;
      phase_q <= `DPP_RST_PHASE;
      step_q <= 1'b0;
    end
    else
    begin
      msb_prev_q <= synth_msb;
      phase_q <= phase_d;
      step_q <= step_d;
    end
  end

endmodule // dpp_phase_path

`default_nettype wire

// >>> shared/dpp_ctrl_regs.vh
/*
  Register offsets, field positions, reset values and constants for the
  phase offset and pattern control register bank.
  Assumes inclusion by bare name from the design files.
*/
`ifndef DPP_CTRL_REGS_VH
`define DPP_CTRL_REGS_VH

// ---------------------------------------------------------------------
// Register offsets (15-bit serial address field)
// ---------------------------------------------------------------------
`define DPP_ADDR_CHAN4_PHASE 15'h0040
`define DPP_ADDR_CHAN3_PHASE 15'h0041
`define DPP_ADDR_CHAN2_PHASE 15'h0042
`define DPP_ADDR_CHAN1_PHASE 15'h0043
`define DPP_ADDR_PAT_CTRL1 15'h0044
`define DPP_ADDR_PAT_CTRL2 15'h0045

// ---------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------
`define DPP_RST_PHASE 16'h0000
`define DPP_RST_PAT_CTRL1 16'h0000
`define DPP_RST_PAT_CTRL2 16'h0000
`define DPP_UNMAPPED_READ 16'h0000

// ---------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------
`define DPP_BIT_FIRST_ONLY_DELAY 1
`define DPP_BIT_CHAN4_COSINE 15
`define DPP_BIT_CHAN4_CNT_CLK 14
`define DPP_BIT_CHAN3_COSINE 11
`define DPP_BIT_CHAN3_CNT_CLK 10
`define DPP_BIT_CHAN3_PHASE_MEM 9

// ---------------------------------------------------------------------
// Phase scaling and serial frame layout
// ---------------------------------------------------------------------
`define DPP_QUARTER_CYCLE 16'h4000
`define DPP_FRAME_LAST_BIT 6'h1f
`define DPP_HEADER_LAST_BIT 6'h0f

`endif

// >>> verification/dpp_ctrl_props.sv
/*
  Checker for the phase offset and pattern control register bank.
  Assumes one clock domain and the port timing of the register bank.
*/
`timescale 1ns/1ps
`default_nettype none

module dpp_ctrl_props (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Serial port
  input wire logic spi_cs_n,
  input wire logic spi_miso_oe_n_q,
  // Synthesizer and memory side
  input wire logic [3:0] synth_msb,
  input wire logic [11:0] chan3_start_address_data,
  input wire logic [15:0] chan3_phase_word,
  input wire logic [15:0] chan4_phase_word,
  input wire logic [3:0] addr_step,
  // Control levels
  input wire logic chan4_cosine_select_q,
  input wire logic chan3_cosine_select_q,
  input wire logic chan4_counter_clock_select_q,
  input wire logic chan3_counter_clock_select_q,
  input wire logic chan3_phase_from_memory_q
);
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // An MSB rise on a channel whose counter steps on the MSB.
  sequence s_rise4;
    chan4_counter_clock_select_q && $rose(synth_msb[3]);
  endsequence
  sequence s_rise3;
    chan3_counter_clock_select_q && $rose(synth_msb[2]);
  endsequence

  a_cos4_rise: assert property ($rose(chan4_cosine_select_q) |=>
    chan4_phase_word == $past(chan4_phase_word) + 16'h4000)
    else $error("chan4 cosine did not add a quarter cycle");
  a_cos4_fall: assert property ($fell(chan4_cosine_select_q) |=>
    chan4_phase_word == $past(chan4_phase_word) - 16'h4000)
    else $error("chan4 sine did not remove the quarter cycle");
  a_cos3_rise: assert property ($rose(chan3_cosine_select_q) |=>
    chan3_phase_word == $past(chan3_phase_word) + 16'h4000)
    else $error("chan3 cosine did not add a quarter cycle");
  a_mem_phase_src: assert property ($past(chan3_phase_from_memory_q) |->
    chan3_phase_word == {$past(chan3_start_address_data[11:4]), 8'h00}
    + ($past(chan3_cosine_select_q) ? 16'h4000 : 16'h0000))
    else $error("chan3 phase not taken from memory top bits");
  a_dac_clk_step: assert property (!chan4_counter_clock_select_q &&
    !chan3_counter_clock_select_q |=> addr_step[3:2] == 2'b11)
    else $error("dac clock step not steady");
  a_low_chan_step: assert property (!$past(srst) |->
    addr_step[1:0] == 2'b11)
    else $error("chan1 or chan2 step not steady");
  a_msb4_step: assert property (s_rise4 |-> ##[1:2] addr_step[3])
    else $error("chan4 msb rise gave no step");
  a_msb3_step: assert property (s_rise3 |-> ##[1:2] addr_step[2])
    else $error("chan3 msb rise gave no step");
  a_msb_step_pulse: assert property (chan4_counter_clock_select_q &&
    $past(chan4_counter_clock_select_q) && addr_step[3] |=> !addr_step[3])
    else $error("chan4 msb step longer than one cycle");
  a_miso_idle_off: assert property (spi_cs_n [*4] |-> spi_miso_oe_n_q)
    else $error("miso driven while deselected");
endmodule // dpp_ctrl_props

bind dpp_ctrl dpp_ctrl_props dpp_ctrl_props_i (.clk(clk), .srst(srst),
  .spi_cs_n(spi_cs_n), .spi_miso_oe_n_q(spi_miso_oe_n_q),
  .synth_msb(synth_msb), .chan3_start_address_data(chan3_start_address_data),
  .chan3_phase_word(chan3_phase_word), .chan4_phase_word(chan4_phase_word),
  .addr_step(addr_step), .chan4_cosine_select_q(chan4_cosine_select_q),
  .chan3_cosine_select_q(chan3_cosine_select_q),
  .chan4_counter_clock_select_q(chan4_counter_clock_select_q),
  .chan3_counter_clock_select_q(chan3_counter_clock_select_q),
  .chan3_phase_from_memory_q(chan3_phase_from_memory_q));
`default_nettype wire

// >>> verification/tb_top.sv
/*
  Self-checking bench for the register bank, driving the serial pins.
  Assumes a 250 MHz clock and sclk phases of five clock cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dpp_ctrl_regs.vh"

module tb_top;
  logic clk, srst, spi_sclk, spi_cs_n, spi_mosi;
  logic [3:0] synth_msb;
  logic [11:0] mem;
  wire miso, oe_n, dly, cos4, cos3, ccs4, ccs3, memsel;
  wire [15:0] ph1, ph2, ph3, ph4;
  wire [3:0] addr_step;
  int bad_count, comparisons;
  int cycles = 0;

  dpp_ctrl dpp_ctrl_i (.clk(clk), .srst(srst), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso_q(miso),
    .spi_miso_oe_n_q(oe_n), .synth_msb(synth_msb),
    .chan3_start_address_data(mem), .chan1_phase_word(ph1),
    .chan2_phase_word(ph2), .chan3_phase_word(ph3), .chan4_phase_word(ph4),
    .addr_step(addr_step), .first_pattern_only_delay_q(dly),
    .chan4_cosine_select_q(cos4), .chan3_cosine_select_q(cos3),
    .chan4_counter_clock_select_q(ccs4),
    .chan3_counter_clock_select_q(ccs3), .chan3_phase_from_memory_q(memsel));

  // ------------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Cuts a hang short after far more cycles than the run needs.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      bad_count = bad_count + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (bad_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk16(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Sends nb bits of a frame MSB first; fewer than 32 aborts it.
  task automatic frame(input logic rw, input logic [14:0] a,
    input logic [15:0] wd, input int nb, output logic [15:0] rd);
    logic [31:0] f;
    f = {rw, a, wd};
    rd = 16'h0000;
    spi_cs_n <= 1'b0;
    cyc(3);
    for (int i = 31; i >= 32 - nb; i--)
    begin
      spi_sclk <= 1'b0;
      spi_mosi <= f[i];
      cyc(5);
      if (i < 16)
        rd[i] = miso;
      if (rw && i == 0)
        chk16("miso_oe_n", 16'h0000, {15'h0000, oe_n});
      spi_sclk <= 1'b1;
      cyc(5);
    end
    spi_sclk <= 1'b0;
    cyc(5);
    spi_cs_n <= 1'b1;
    cyc(8);
  endtask

  task automatic wr(input logic [14:0] a, input logic [15:0] d);
    logic [15:0] x;
    frame(1'b0, a, d, 32, x);
  endtask

  task automatic rchk(input string what, input logic [14:0] a,
    input logic [15:0] exp);
    logic [15:0] x;
    frame(1'b1, a, 16'h0000, 32, x);
    chk16(what, exp, x);
  endtask

  task automatic do_reset();
    srst <= 1'b1;
    cyc(20);
    srst <= 1'b0;
    cyc(3);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset_vals();
    for (int k = 0; k < 6; k++)
      rchk("reg reset", 15'h0040 + k[14:0], 16'h0000);
    rchk("unmapped", 15'h0050, `DPP_UNMAPPED_READ);
    chk16("phase reset", 16'h0000, ph1 | ph2 | ph3 | ph4);
    chk16("ctrl reset", 16'h0000,
      {10'h000, dly, cos4, cos3, ccs4, ccs3, memsel});
  endtask

  task automatic t_phase_rw();
    logic [15:0] v [4];
    v = '{16'hc000, 16'h8000, 16'h4000, 16'h1234};
    for (int k = 0; k < 4; k++)
      wr(15'h0040 + k[14:0], v[k]);
    wr(15'h0050, 16'hffff);
    for (int k = 0; k < 4; k++)
      rchk("phase reg", 15'h0040 + k[14:0], v[k]);
    rchk("unmapped", 15'h0050, 16'h0000);
    chk16("chan4 phase", v[0], ph4);
    chk16("chan3 phase", v[1], ph3);
    chk16("chan2 phase", v[2], ph2);
    chk16("chan1 phase", v[3], ph1);
  endtask

  task automatic t_pattern();
    wr(`DPP_ADDR_PAT_CTRL1, 16'h0002);
    chk16("delay bit", 16'h0001, {15'h0000, dly});
    rchk("ctrl1", `DPP_ADDR_PAT_CTRL1, 16'h0002);
    wr(`DPP_ADDR_PAT_CTRL1, 16'h8001);
    chk16("delay bit", 16'h0000, {15'h0000, dly});
    rchk("ctrl1 reserved", `DPP_ADDR_PAT_CTRL1, 16'h8001);
    wr(`DPP_ADDR_PAT_CTRL1, 16'h0000);
    wr(`DPP_ADDR_PAT_CTRL2, 16'h8800);
    chk16("chan4 cosine", 16'h0000, ph4);
    chk16("chan3 cosine", 16'hc000, ph3);
    chk16("chan2 sine", 16'h4000, ph2);
    wr(`DPP_ADDR_PAT_CTRL2, 16'h0000);
    chk16("chan4 sine", 16'hc000, ph4);
  endtask

  task automatic t_mem();
    mem <= 12'habc;
    wr(`DPP_ADDR_PAT_CTRL2, 16'h0200);
    chk16("mem select", 16'h0001, {15'h0000, memsel});
    chk16("chan3 from mem", 16'hab00, ph3);
    mem <= 12'h5f3;
    cyc(3);
    chk16("chan3 from mem", 16'h5f00, ph3);
    wr(`DPP_ADDR_PAT_CTRL2, 16'h0a00);
    chk16("chan3 mem cosine", 16'h9f00, ph3);
    wr(`DPP_ADDR_PAT_CTRL2, 16'h0000);
    chk16("chan3 from reg", 16'h8000, ph3);
  endtask

  task automatic t_counter();
    int n4, n3;
    wr(`DPP_ADDR_PAT_CTRL2, 16'h4400);
    chk16("steps msb low", 16'h0003, {12'h000, addr_step});
    n4 = 0;
    n3 = 0;
    for (int j = 0; j < 28; j++)
    begin
      synth_msb <= (j % 8 < 4 && j < 24) ? 4'hf : 4'h0;
      cyc(1);
      n4 = n4 + addr_step[3];
      n3 = n3 + addr_step[2];
    end
    chk16("chan4 steps", 16'h0003, n4[15:0]);
    chk16("chan3 steps", 16'h0003, n3[15:0]);
    wr(`DPP_ADDR_PAT_CTRL2, 16'h0000);
    chk16("steps dac clk", 16'h000f, {12'h000, addr_step});
  endtask

  task automatic t_abort();
    logic [15:0] x;
    frame(1'b0, `DPP_ADDR_CHAN3_PHASE, 16'h1111, 20, x);
    rchk("aborted write", `DPP_ADDR_CHAN3_PHASE, 16'h8000);
  endtask

  initial
  begin
    srst = 1'b1;
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    synth_msb = 4'h0;
    mem = 12'h000;
    bad_count = 0;
    comparisons = 0;
    @(posedge clk);
    do_reset();
    t_reset_vals();
    t_phase_rw();
    t_pattern();
    t_mem();
    t_counter();
    t_abort();
    do_reset();
    t_reset_vals();
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
